// File: src/host_port.sv
`timescale 1ns/1ns
`include "host_port_consts.svh"

// ----------------------------------------
// word buffer between byte assembly and memory
// ----------------------------------------
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : word_fifo

// ----------------------------------------
// host port controller
// ----------------------------------------
module host_bus_controller #(
    parameter logic [3:0] PRODUCT_TYPE = 4'hA, // arbitrary code value
    parameter logic [3:0] RELEASE_NUM = 4'hC, // arbitrary code value
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host bus
    input wire logic [9:0] isa_addr,
    input wire logic isa_aen,
    input wire logic isa_iow_n,
    input wire logic isa_ior_n,
    input wire logic [7:0] isa_data_in,
    output logic [7:0] isa_data_out,
    output logic isa_data_oe,
    // base address jumpers
    input wire logic [2:0] base_sel,
    // hardware trigger
    input wire logic hw_trigger_n,
    // generator status
    input wire host_port_pkg::gen_status_t gen_status,
    // generator control
    output logic gen_hold_reset,
    output logic gen_start,
    output logic flag_clk,
    output logic [7:0] flag_pattern,
    // memory write port
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output host_port_pkg::mem_write_t mem_wr
);
    localparam int WB = `WORD_BITS;
    localparam int AB = `ADDR_BITS;

    function automatic logic [9:0] base_of(input logic [2:0] sel);
        case (sel)
            3'h0: base_of = 10'h300;
            3'h1: base_of = 10'h320;
            3'h2: base_of = 10'h340;
            3'h3: base_of = 10'h260;
            3'h4: base_of = 10'h280;
            3'h5: base_of = 10'h270;
            3'h6: base_of = 10'h290;
            default: base_of = 10'h360;
        endcase
    endfunction : base_of

    function automatic logic hit(input logic [9:0] a, input logic [2:0] sel);
        logic [9:0] b;
        b = base_of(sel);
        hit = (a[9:3] == b[9:3]);
    endfunction : hit

    // ----------------------------------------
    // bus write capture
    // ----------------------------------------
    logic iow_prev;
    logic take;
    logic cmd_go;
    logic [2:0] cmd_ofs;
    logic [7:0] cmd_byte;

    assign take = iow_prev && !isa_iow_n && !isa_aen && hit(isa_addr, base_sel);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            iow_prev <= 1'b1;
            cmd_go <= 1'b0;
            cmd_ofs <= 3'h0;
            cmd_byte <= 8'h00;
        end else begin
            iow_prev <= isa_iow_n;
            cmd_go <= take;
            if (take) begin
                cmd_ofs <= isa_addr[2:0];
                cmd_byte <= isa_data_in;
            end
        end
    end

    logic do_count;
    logic do_select;
    logic do_clear;
    logic do_flag;
    logic do_load;
    logic do_arm;
    logic do_start;
    logic do_reset;
    assign do_count = cmd_go && (cmd_ofs == `OFS_BYTE_COUNT);
    assign do_select = cmd_go && (cmd_ofs == `OFS_SELECT);
    assign do_clear = cmd_go && (cmd_ofs == `OFS_CLEAR_PTR);
    assign do_flag = cmd_go && (cmd_ofs == `OFS_FLAG_STROBE);
    assign do_load = cmd_go && (cmd_ofs == `OFS_LOAD);
    assign do_arm = cmd_go && (cmd_ofs == `OFS_ARM);
    assign do_start = cmd_go && (cmd_ofs == `OFS_SW_START);
    assign do_reset = cmd_go && (cmd_ofs == `OFS_CTRL_RESET);

    // ----------------------------------------
    // initialisation order and arming
    // ----------------------------------------
    host_port_pkg::init_state_t init_state;
    host_port_pkg::init_state_t next_init_state;
    logic armed;
    logic setup_error_flag;
    logic in_reset;
    logic trig_prev;
    logic trig_fall;
    logic order_bad;
    logic load_overflow;

    assign trig_fall = trig_prev && !hw_trigger_n;
    assign armed = (init_state == host_port_pkg::INIT_ARMED);
    assign order_bad = (do_load || do_arm) && (init_state != host_port_pkg::INIT_CLEARED);

    always_comb begin
        next_init_state = init_state;
        case (init_state)
            host_port_pkg::INIT_BLANK: begin
                if (do_count) next_init_state = host_port_pkg::INIT_COUNT;
            end
            host_port_pkg::INIT_COUNT: begin
                if (do_select) next_init_state = host_port_pkg::INIT_SELECT;
            end
            host_port_pkg::INIT_SELECT: begin
                if (do_clear) next_init_state = host_port_pkg::INIT_CLEARED;
            end
            host_port_pkg::INIT_CLEARED: begin
                if (do_arm) next_init_state = host_port_pkg::INIT_ARMED;
            end
            host_port_pkg::INIT_ARMED: begin
                next_init_state = host_port_pkg::INIT_ARMED;
            end
            default: next_init_state = host_port_pkg::INIT_BLANK;
        endcase
        if (do_reset) begin
            next_init_state = host_port_pkg::INIT_BLANK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_state <= host_port_pkg::INIT_BLANK;
        end else begin
            init_state <= next_init_state;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            setup_error_flag <= 1'b0;
        end else if (order_bad || load_overflow) begin
            setup_error_flag <= 1'b1;
        end else if (do_reset) begin
            setup_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_prev <= 1'b1;
            gen_start <= 1'b0;
            in_reset <= 1'b1;
        end else begin
            trig_prev <= hw_trigger_n;
            gen_start <= armed && !do_reset && (do_start || trig_fall);
            if (do_reset) begin
                in_reset <= 1'b1;
            end else if (gen_start) begin
                in_reset <= 1'b0;
            end
        end
    end
    assign gen_hold_reset = in_reset;

    // ----------------------------------------
    // output flag initialisation
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_clk <= 1'b0;
            flag_pattern <= 8'h00;
        end else begin
            flag_clk <= do_flag && in_reset;
            if (do_flag && in_reset) begin
                flag_pattern <= cmd_byte;
            end
        end
    end

    // ----------------------------------------
    // peripheral select, byte count, word assembly
    // ----------------------------------------
    logic target;
    logic [3:0] bytes_per_word;
    logic [3:0] byte_cnt;
    logic [WB-1:0] word_acc;
    logic [AB-1:0] load_ptr;
    logic word_done;
    logic fifo_in_ready;
    logic push;
    host_port_pkg::mem_write_t push_entry;

    assign word_done = do_load && !order_bad && (byte_cnt + 4'h1 >= bytes_per_word);
    assign push = word_done && fifo_in_ready;
    assign load_overflow = word_done && !fifo_in_ready;
    assign push_entry = '{target: target, addr: load_ptr,
                          data: {word_acc[WB-9:0], cmd_byte}};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            target <= `RST_SELECT;
            bytes_per_word <= `RST_BYTES;
        end else begin
            if (do_select) begin
                target <= cmd_byte[0];
            end
            if (do_count) begin
                bytes_per_word <= cmd_byte[3:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            byte_cnt <= 4'h0;
            word_acc <= '0;
        end else if (do_clear || do_count || do_reset) begin
            byte_cnt <= 4'h0;
            word_acc <= '0;
        end else if (do_load && !order_bad) begin
            if (word_done) begin
                byte_cnt <= 4'h0;
                word_acc <= '0;
            end else begin
                byte_cnt <= byte_cnt + 4'h1;
                word_acc <= {word_acc[WB-9:0], cmd_byte};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_ptr <= '0;
        end else if (do_clear) begin
            load_ptr <= '0;
        end else if (push) begin
            load_ptr <= load_ptr + 1'b1;
        end
    end

    word_fifo #(
        .WIDTH($bits(host_port_pkg::mem_write_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_entry),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data(mem_wr)
    );

    // ----------------------------------------
    // readback
    // ----------------------------------------
    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[`ST_MEM_MODE] = gen_status.mem_mode;
        status_byte[`ST_ERROR] = setup_error_flag;
        status_byte[`ST_ARMED] = armed;
        status_byte[`ST_IDLE] = !gen_status.running && !gen_status.waiting;
        status_byte[`ST_WAITING] = gen_status.waiting;
        status_byte[`ST_RUNNING] = gen_status.running;
        status_byte[`ST_RESET] = in_reset;
        status_byte[`ST_STOPPED] = gen_status.stopped;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            isa_data_out <= 8'h00;
        end else begin
            case (isa_addr[2:0])
                `OFS_STATUS: isa_data_out <= status_byte;
                `OFS_VERSION: isa_data_out <= {PRODUCT_TYPE, RELEASE_NUM};
                `OFS_PTR_LOW: isa_data_out <= gen_status.ip[7:0];
                `OFS_PTR_HIGH: isa_data_out <= gen_status.ip[15:8];
                `OFS_COUNT_B0: isa_data_out <= gen_status.interval[7:0];
                `OFS_COUNT_B1: isa_data_out <= gen_status.interval[15:8];
                `OFS_FLOW: isa_data_out <= {1'b0, gen_status.flow_mux, gen_status.flow_op};
                `OFS_JUMP_LOW: isa_data_out <= gen_status.jump;
                default: isa_data_out <= 8'h00;
            endcase
        end
    end
    assign isa_data_oe = !isa_ior_n && !isa_aen && hit(isa_addr, base_sel);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_start_needs_arm: assert property (gen_start |-> $past(armed))
        else $error("start issued while not armed");
    a_start_follows_cmd: assert property (
        (do_start && armed && !do_reset) |=> gen_start)
        else $error("armed start command did not start");
    a_reset_disarms: assert property (do_reset |=> !armed && in_reset ##1 !armed)
        else $error("controller reset left the generator armed");
    a_flag_in_reset: assert property (flag_clk |-> $past(in_reset) && $past(do_flag))
        else $error("flag latch clocked outside reset");
    a_ptr_clears: assert property (do_clear |=> load_ptr == '0)
        else $error("load pointer not cleared");
    a_write_decode: assert property (take |=> cmd_go
        && cmd_ofs == $past(isa_addr[2:0]) && cmd_byte == $past(isa_data_in))
        else $error("qualified bus write not taken");
    a_no_dma_write: assert property (isa_aen |=> !cmd_go)
        else $error("write taken during address enable");
    a_order_error: assert property (order_bad |=> setup_error_flag ##1 setup_error_flag)
        else $error("out of order command not flagged");
    a_idle_bit: assert property ((isa_addr[2:0] == `OFS_STATUS) |=>
        isa_data_out[`ST_IDLE] == !($past(gen_status.running) || $past(gen_status.waiting)))
        else $error("idle bit missing");
    a_read_enable: assert property (isa_data_oe |-> !isa_ior_n && !isa_aen)
        else $error("data driven outside a read");
    a_word_msb_first: assert property (
        (do_load && !order_bad && !word_done) |=> word_acc[7:0] == $past(cmd_byte))
        else $error("load byte not shifted in");
endmodule : host_bus_controller

// File: src/host_port_consts.svh
// How it works
// - Peripheral select register routes loads; 0 is program memory (default), 1 synthesis core.
// - Load pointer cannot be loaded; it only clears to zero, loads continue onward.
// - Flag strobe write while generator held in reset pulses the output latch clock.
// - Memory words are assembled from successive load bytes, most significant byte first.
// - Triggers and software starts are ignored until the arm command is received.
// - Once armed, next hardware trigger or software start begins execution.
// - Controller reset command resets generator and clears armed state until reinitialised.
// - Eight-bit read-only registers at base offsets return status and version.
// - Writes to readback offsets update the command sharing that offset.
// - Status bit 6 shows a setup error occurred while programming the port.
// - Status bit 5 shows programmed and armed.
// - Status bit 3 shows execution waiting for the next trigger.
// - Status bit 2 shows the generator is executing.
// - Status bit 1 shows the generator is in reset.
// - Status bit 0 shows a halt was executed and generator stopped.
// - Status bit 7 reflects test storage mode; bit 4 reports idle.
// - Version register: product type upper nibble, release number lower nibble.
// - Offsets 2 and 3 return instruction pointer low and high bytes.
// - Offsets 4 and 5 return the low two interval countdown bytes, least significant first.
// - Flow readback: multiplexer select in bits 6..4, opcode in bits 3..0.
// - Offset 7 returns low eight bits of current jump target.
// - Bus write latched only with address enable low and write strobe low.
// - Eight consecutive locations from base to base plus 7 are decoded.
// - Data commands use the latched byte; others ignore it.
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// command offsets
`define OFS_BYTE_COUNT 3'h0
`define OFS_SELECT 3'h1
`define OFS_CLEAR_PTR 3'h2
`define OFS_FLAG_STROBE 3'h3
`define OFS_LOAD 3'h4
`define OFS_ARM 3'h5
`define OFS_SW_START 3'h6
`define OFS_CTRL_RESET 3'h7
// readback offsets
`define OFS_STATUS 3'h0
`define OFS_VERSION 3'h1
`define OFS_PTR_LOW 3'h2
`define OFS_PTR_HIGH 3'h3
`define OFS_COUNT_B0 3'h4
`define OFS_COUNT_B1 3'h5
`define OFS_FLOW 3'h6
`define OFS_JUMP_LOW 3'h7
// status bit positions
`define ST_STOPPED 0
`define ST_RESET 1
`define ST_RUNNING 2
`define ST_WAITING 3
`define ST_IDLE 4
`define ST_ARMED 5
`define ST_ERROR 6
`define ST_MEM_MODE 7
// reset values
`define RST_SELECT 1'h0
`define RST_BYTES 4'hA
// field widths
`define WORD_BITS 96
`define ADDR_BITS 15

`endif

// File: src/host_port_pkg.sv
`include "host_port_consts.svh"
package host_port_pkg;

    typedef struct packed {
        logic target;
        logic [`ADDR_BITS-1:0] addr;
        logic [`WORD_BITS-1:0] data;
    } mem_write_t;

    typedef struct packed {
        logic running;
        logic waiting;
        logic stopped;
        logic mem_mode;
        logic [15:0] ip;
        logic [31:0] interval;
        logic [2:0] flow_mux;
        logic [3:0] flow_op;
        logic [7:0] jump;
    } gen_status_t;

    typedef enum logic [4:0] {
        INIT_BLANK = 5'h01,
        INIT_COUNT = 5'h02,
        INIT_SELECT = 5'h04,
        INIT_CLEARED = 5'h08,
        INIT_ARMED = 5'h10
    } init_state_t;

endpackage : host_port_pkg

// File: verif/isa_host.sv
`timescale 1ns/1ns

// ----------------------------------------
// host processor on the i/o bus
// ----------------------------------------
module isa_host (
    // clock
    input wire logic clk,
    // bus lines driven by the host
    output logic [9:0] isa_addr,
    output logic isa_aen,
    output logic isa_iow_n,
    output logic isa_ior_n,
    output logic [7:0] isa_data_in,
    // bus lines driven by the card
    input wire logic [7:0] isa_data_out,
    input wire logic isa_data_oe,
    // read result, one cycle per read
    output logic rd_done,
    output logic [8:0] rd_data
);
    initial begin
        isa_addr = 10'h000;
        isa_aen = 1'b1;
        isa_iow_n = 1'b1;
        isa_ior_n = 1'b1;
        isa_data_in = 8'h00;
        rd_done = 1'b0;
        rd_data = 9'h000;
    end

    // strobe held two edges, then high one edge before the next cycle
    task io_write(input logic [9:0] a, input logic [7:0] d, input logic aen);
        @(negedge clk);
        isa_addr = a;
        isa_aen = aen;
        isa_data_in = d;
        isa_iow_n = 1'b0;
        @(negedge clk);
        @(negedge clk);
        isa_iow_n = 1'b1;
        isa_aen = 1'b1;
        isa_data_in = ~d;
        @(negedge clk);
    endtask : io_write

    // output is registered, so sample after two edges
    task io_read(input logic [9:0] a);
        @(negedge clk);
        isa_addr = a;
        isa_aen = 1'b0;
        isa_ior_n = 1'b0;
        @(negedge clk);
        @(negedge clk);
        rd_data = {isa_data_oe, isa_data_out};
        rd_done = 1'b1;
        isa_ior_n = 1'b1;
        isa_aen = 1'b1;
        @(negedge clk);
        rd_done = 1'b0;
    endtask : io_read
endmodule : isa_host

// File: verif/tb.sv
`timescale 1ns/1ns
`include "host_port_consts.svh"

module tb;
    localparam logic [9:0] BASE = 10'h340;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] isa_addr;
    logic isa_aen;
    logic isa_iow_n;
    logic isa_ior_n;
    logic [7:0] isa_data_in;
    logic [7:0] isa_data_out;
    logic isa_data_oe;
    logic [2:0] base_sel = 3'h2;
    logic hw_trigger_n = 1'b1;
    host_port_pkg::gen_status_t gen_status = '0;
    logic gen_hold_reset;
    logic gen_start;
    logic flag_clk;
    logic [7:0] flag_pattern;
    logic mem_wr_valid;
    logic mem_wr_ready = 1'b0;
    host_port_pkg::mem_write_t mem_wr;
    logic rd_done;
    logic [8:0] rd_data;
    logic stall = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [8:0] exp_rd[$];
    logic [7:0] exp_flag[$];
    logic exp_start[$];
    host_port_pkg::mem_write_t exp_mem[$];
    logic [3:0] flags[4] = '{4'b0001, 4'b0010, 4'b0100, 4'b1100};
    logic [7:0] st_exp[4] = '{8'h24, 8'h28, 8'h31, 8'hB1};

    always #20 clk = ~clk;

    host_bus_controller host_bus_controller_i (
        .clk(clk), .reset(reset), .isa_addr(isa_addr), .isa_aen(isa_aen),
        .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_data_in(isa_data_in),
        .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe), .base_sel(base_sel),
        .hw_trigger_n(hw_trigger_n), .gen_status(gen_status),
        .gen_hold_reset(gen_hold_reset), .gen_start(gen_start), .flag_clk(flag_clk),
        .flag_pattern(flag_pattern), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr)
    );

    isa_host host_i (
        .clk(clk), .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_iow_n(isa_iow_n),
        .isa_ior_n(isa_ior_n), .isa_data_in(isa_data_in), .isa_data_out(isa_data_out),
        .isa_data_oe(isa_data_oe), .rd_done(rd_done), .rd_data(rd_data)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string nm, input logic [111:0] e, input logic [111:0] g);
        n_tests++;
        if (e !== g) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task wr(input logic [2:0] o, input logic [7:0] d);
        host_i.io_write(BASE | {7'h00, o}, d, 1'b0);
    endtask : wr

    task rd(input logic [2:0] o, input logic [7:0] e);
        exp_rd.push_back({1'b1, e});
        host_i.io_read(BASE | {7'h00, o});
    endtask : rd

    task init(input logic [3:0] bpw, input logic sel);
        wr(`OFS_BYTE_COUNT, {4'h0, bpw});
        wr(`OFS_SELECT, {7'h00, sel});
        wr(`OFS_CLEAR_PTR, 8'($urandom));
    endtask : init

    task trig;
        @(negedge clk);
        hw_trigger_n = 1'b0;
        repeat (2) @(negedge clk);
        hw_trigger_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : trig

    // words of bpw random bytes, first byte most significant
    task load_words(input logic tgt, input int n, input int bpw, input int keep);
        logic [7:0] b[12];
        host_port_pkg::mem_write_t e;
        for (int w = 0; w < n; w++) begin
            e.target = tgt;
            e.addr = 15'(w);
            e.data = '0;
            for (int k = 0; k < bpw; k++) begin
                b[k] = 8'($urandom);
                e.data = {e.data[87:0], b[k]};
            end
            if (w < keep) exp_mem.push_back(e);
            for (int k = 0; k < bpw; k++) wr(`OFS_LOAD, b[k]);
        end
    endtask : load_words

    // ----------------------------------------
    // generator memory and output monitor
    // ----------------------------------------
    always @(negedge clk) mem_wr_ready <= stall ? 1'b0 : 1'($urandom);

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles >= 20000) begin
            miscompares++;
            give_verdict();
        end else if (!reset) begin
            if (rd_done === 1'b1) begin
                chk("read", exp_rd.size() ? exp_rd.pop_front() : 'x, rd_data);
            end
            if (flag_clk === 1'b1) begin
                chk("flag_pattern", exp_flag.size() ? exp_flag.pop_front() : 'x,
                    flag_pattern);
            end
            if (gen_start === 1'b1) begin
                chk("gen_start", exp_start.size() ? 1'b1 : 'x, gen_start);
                if (exp_start.size()) exp_start.pop_front();
            end
            if (mem_wr_valid === 1'b1 && mem_wr_ready) begin
                chk("mem_wr", exp_mem.size() ? exp_mem.pop_front() : 'x, mem_wr);
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(50));
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        gen_status.ip = 16'($urandom);
        gen_status.interval = $urandom;
        gen_status.flow_mux = 3'($urandom);
        gen_status.flow_op = 4'($urandom);
        gen_status.jump = 8'($urandom);
        rd(`OFS_STATUS, 8'h12);
        chk("gen_hold_reset", 112'h1, 112'(gen_hold_reset));
        rd(`OFS_VERSION, 8'hAC);
        rd(`OFS_PTR_LOW, gen_status.ip[7:0]);
        rd(`OFS_PTR_HIGH, gen_status.ip[15:8]);
        rd(`OFS_COUNT_B0, gen_status.interval[7:0]);
        rd(`OFS_COUNT_B1, gen_status.interval[15:8]);
        rd(`OFS_FLOW, {1'b0, gen_status.flow_mux, gen_status.flow_op});
        rd(`OFS_JUMP_LOW, gen_status.jump);
        exp_flag.push_back(8'($urandom));
        wr(`OFS_FLAG_STROBE, exp_flag[0]);
        wr(`OFS_LOAD, 8'h5A);
        wr(`OFS_ARM, 8'h00);
        wr(`OFS_SW_START, 8'h00);
        trig();
        rd(`OFS_STATUS, 8'h52);
        host_i.io_write(BASE | 10'h007, 8'h00, 1'b1);
        host_i.io_write(10'h307, 8'h00, 1'b0);
        rd(`OFS_STATUS, 8'h52);
        wr(`OFS_CTRL_RESET, 8'h00);
        rd(`OFS_STATUS, 8'h12);
        init(4'h2, 1'b0);
        load_words(1'b0, 3, 2, 3);
        wr(`OFS_ARM, 8'h00);
        rd(`OFS_STATUS, 8'h32);
        exp_start.push_back(1'b1);
        trig();
        chk("gen_hold_reset", 112'h0, 112'(gen_hold_reset));
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {gen_status.mem_mode, gen_status.stopped, gen_status.waiting,
             gen_status.running} = flags[i];
            rd(`OFS_STATUS, st_exp[i]);
        end
        wr(`OFS_FLAG_STROBE, 8'h3C);
        @(negedge clk);
        gen_status[66:63] = 4'h0;
        wr(`OFS_CTRL_RESET, 8'h00);
        rd(`OFS_STATUS, 8'h12);
        chk("gen_hold_reset", 112'h1, 112'(gen_hold_reset));
        wr(`OFS_SW_START, 8'h00);
        init(4'h3, 1'b1);
        load_words(1'b1, 1, 3, 1);
        wr(`OFS_ARM, 8'h00);
        exp_start.push_back(1'b1);
        wr(`OFS_SW_START, 8'h00);
        wr(`OFS_CTRL_RESET, 8'h00);
        init(4'h1, 1'b0);
        stall = 1'b1;
        load_words(1'b0, 17, 1, 16);
        rd(`OFS_STATUS, 8'h52);
        stall = 1'b0;
        repeat (80) @(negedge clk);
        chk("pending", 112'h0, 112'(exp_rd.size() + exp_mem.size() + exp_flag.size()
            + exp_start.size()));
        give_verdict();
    end
endmodule : tb
